// ---- rtl/asr_pkg.sv ----
package asr_pkg;
    // Frame geometry
    localparam int unsigned FRAME_BITS    = 16;
    localparam logic [4:0]  FRAME_LEN     = 5'h10;       // Rising edges in a good frame
    localparam logic [4:0]  CNT_MAX       = 5'h1f;       // Edge counter saturates here
    // Request field positions
    localparam int unsigned TAG1_POS      = 15;
    localparam int unsigned TAG0_POS      = 14;
    localparam int unsigned READ_FLAG_POS = 13;
    localparam int unsigned TAG2_POS      = 12;
    // Response field positions
    localparam int unsigned PARITY_POS    = 12;
    // Response kinds
    localparam logic [1:0]  KIND_NORMAL   = 2'h1;
    localparam logic [1:0]  KIND_SELF     = 2'h2;
    localparam logic [1:0]  KIND_EXC      = 2'h3;
    // Exception status code used for sensor error reports (no value is defined)
    localparam logic [1:0]  EXC_KIND_SENS = 2'h0;
    // Response word before the first completed read: only the parity bit set
    localparam logic [15:0] RESP_RESET    = 16'h1000;
    // Control values after reset
    localparam logic [1:0]  POLICY_RESET  = 2'h0;
    localparam logic        FLAG_RESET    = 1'h0;

    // Output freeze policies
    typedef enum logic [1:0] {
        POL_ALL  = 2'h0,   // Freeze both until all four registers read
        POL_CHAN = 2'h1,   // Freeze one channel until its pair is read
        POL_MSB  = 2'h2,   // Freeze both until both high parts read
        POL_FREE = 2'h3    // Continuous update
    } asr_policy_type;

    // Frame tracker states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } asr_frame_type;
endpackage : asr_pkg

// ---- rtl/asr_pin_if.sv ----
`timescale 1ns/1ps
interface asr_pin_if;
    logic sck_rise;  // Filtered serial clock rose
    logic sck_fall;  // Filtered serial clock fell
    logic ss_fall;   // Select asserted
    logic ss_rise;   // Select released
    logic mosi;      // Filtered serial data in

    modport sync (output sck_rise, sck_fall, ss_fall, ss_rise, mosi);
    modport core (input  sck_rise, sck_fall, ss_fall, ss_rise, mosi);
endinterface : asr_pin_if

// ---- rtl/asr_pin_sync.sv ----
`timescale 1ns/1ps
module asr_pin_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sck_raw,
    input  wire logic ss_n_raw,
    input  wire logic mosi_raw,
    asr_pin_if.sync   pins
);
    import asr_pkg::*;

    logic [2:0] s1_q, s2_q, s3_q;  // Three-stage chains: {mosi, ss_n, sck}
    logic [2:0] lvl_q, lvl_d;      // Accepted levels
    logic [3:0] edg_q, edg_d;      // Edge pulses: ss_rise, ss_fall, sck_fall, sck_rise

    // A level is accepted only when stages two and three agree
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < 3; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
        edg_d = {lvl_d[1] & ~lvl_q[1], ~lvl_d[1] & lvl_q[1],
                 ~lvl_d[0] & lvl_q[0], lvl_d[0] & ~lvl_q[0]};
    end

    // Idle levels at reset: clock low, select high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= 3'h2;
            s2_q  <= 3'h2;
            s3_q  <= 3'h2;
            lvl_q <= 3'h2;
            edg_q <= 4'h0;
        end else begin
            s1_q  <= {mosi_raw, ss_n_raw, sck_raw};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
            edg_q <= edg_d;
        end
    end

    // Same latency on every pin keeps data and clock in step
    assign pins.sck_rise = edg_q[0];
    assign pins.sck_fall = edg_q[1];
    assign pins.ss_fall  = edg_q[2];
    assign pins.ss_rise  = edg_q[3];
    assign pins.mosi     = lvl_q[2];
endmodule : asr_pin_sync

// ---- rtl/asr_sample_readout.sv ----
`timescale 1ns/1ps
// Overview of operation
// - 16-bit frames, MSB first, mode 0
// - Request bit 13 set means sample read
// - Bits 1:0 pick x/yz, low/high part
// - Request bits 11:4 are ignored
// - Response bits 15:13 carry the tag
// - Bit 12 makes the response odd parity
// - Bits 11:10 say what low bits hold
// - Self-test or compensation off gives kind 10
// - Data right-aligned, upper bits zero-filled
// - Bits 9:8 carry the exception code
// - Exception bits 7:4, 1:0 carry nothing
// - Bit 3 flags read during power-down
// - Bit 2 flags heater loop out of regulation
// - Policy 00: freeze both until four parts read
// - Policy 01: freeze channel until pair read
// - Policy 10: freeze both until both high parts
// - Policy 11: outputs follow every sample; a sample arriving in a read cycle is dropped
// - High part upper ten, low part four bits
// - 14-bit two's complement, 800 counts per g
// - 10-bit use reads high parts only
// - Compensation-off flag disables compensation
// - Sleep request enters power-down
// - All control bits start at zero
module asr_sample_readout #(
    parameter int unsigned SAMPLE_W = 14   // Filter output width
) (
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    input  wire logic                    SCK,
    input  wire logic                    SS_N,
    input  wire logic                    MOSI,
    output logic                         MISO,
    output logic                         MISO_OE,
    input  wire logic [SAMPLE_W-1:0]     X_SAMPLE,
    input  wire logic [SAMPLE_W-1:0]     YZ_SAMPLE,
    input  wire logic                    SAMPLE_VALID,
    input  asr_pkg::asr_policy_type      FREEZE_POLICY,
    input  wire logic                    SELF_CHECK_ON,
    input  wire logic                    COMP_OFF,
    input  wire logic                    SLEEP_REQUEST,
    input  wire logic                    LOOP_FAULT,
    output logic                         POWER_DOWN,
    output logic                         TEMP_COMP_OFF,
    output logic                         X_FROZEN,
    output logic                         YZ_FROZEN
);
    import asr_pkg::*;

    // Odd parity over the whole word is placed in bit 12
    function automatic logic [15:0] build_resp(input logic [2:0] tag,
                                               input logic [1:0] kind,
                                               input logic [9:0] low);
        logic [15:0] w;
        w             = {tag, 1'b0, kind, low};
        w[PARITY_POS] = ~(^w);
        return w;
    endfunction : build_resp

    asr_pin_if pins ();   // Filtered pin events

    asr_pin_sync u_sync (
        .clk      (CLK),
        .rst_n    (RST_N),
        .sck_raw  (SCK),
        .ss_n_raw (SS_N),
        .mosi_raw (MOSI),
        .pins     (pins.sync)
    );

    // Control copies
    asr_policy_type pol_q,   pol_d;     // Freeze policy
    logic           self_q,  self_d;    // Self-test enabled
    logic           comp_q,  comp_d;    // Compensation off
    logic           sleep_q, sleep_d;   // Power-down
    logic           fault_q, fault_d;   // Heater loop fault

    // Frame tracker
    asr_frame_type  st_q,    st_d;      // Frame state
    logic [4:0]     cnt_q,   cnt_d;     // Rising edges this frame
    logic [15:0]    rx_q,    rx_d;      // Incoming shift
    logic [15:0]    tx_q,    tx_d;      // Outgoing shift
    logic           oe_q,    oe_d;      // MISO driven
    logic [15:0]    req_q,   req_d;     // Last good request
    logic           done_q,  done_d;    // One-cycle: request ready

    // Readout state
    logic [15:0]          resp_q, resp_d;  // Answer for the next frame
    logic [SAMPLE_W-1:0]  xh_q,   xh_d;    // Held x sample
    logic [SAMPLE_W-1:0]  yh_q,   yh_d;    // Held y/z sample
    logic [1:0]           frz_q,  frz_d;   // Frozen: {yz, x}
    logic [3:0]           rd_q,   rd_d;    // Parts read: yzH, xH, yzL, xL

    // Decoded request
    logic                 rd_now;   // Sample read taken this cycle
    logic                 err_now;  // That read reports an error
    logic [2:0]           tag;      // Tag for the response
    logic [3:0]           part;     // One-hot part selected
    logic [9:0]           low10;    // Data field for the response
    logic [SAMPLE_W-1:0]  word;     // Selected held sample

    // Control bits follow the control register; its reset is all zero
    always_comb begin
        pol_d   = FREEZE_POLICY;
        self_d  = SELF_CHECK_ON;
        comp_d  = COMP_OFF;
        sleep_d = SLEEP_REQUEST;
        fault_d = LOOP_FAULT;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pol_q   <= asr_policy_type'(POLICY_RESET);
            self_q  <= FLAG_RESET;
            comp_q  <= FLAG_RESET;
            sleep_q <= FLAG_RESET;
            fault_q <= FLAG_RESET;
        end else begin
            pol_q   <= pol_d;
            self_q  <= self_d;
            comp_q  <= comp_d;
            sleep_q <= sleep_d;
            fault_q <= fault_d;
        end
    end

    // Frame: sample on rising, shift out on falling, decide on release
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        rx_d   = rx_q;
        tx_d   = tx_q;
        oe_d   = oe_q;
        req_d  = req_q;
        done_d = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                if (pins.ss_fall) begin
                    st_d  = ST_BUSY;
                    cnt_d = 5'h0;
                    tx_d  = resp_q;
                    oe_d  = 1'b1;
                end
            end
            ST_BUSY: begin
                if (pins.ss_rise) begin
                    st_d = ST_IDLE;
                    oe_d = 1'b0;
                    // A frame of the wrong length leaves the answer as it was
                    if (cnt_q == FRAME_LEN) begin
                        req_d  = rx_q;
                        done_d = 1'b1;
                    end
                end else begin
                    if (pins.sck_rise) begin
                        rx_d = {rx_q[14:0], pins.mosi};
                        if (cnt_q != CNT_MAX) begin
                            cnt_d = cnt_q + 5'h1;
                        end
                    end
                    // First bit already stands before the first rising edge
                    if (pins.sck_fall && cnt_q != 5'h0) begin
                        tx_d = {tx_q[14:0], 1'b0};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q   <= ST_IDLE;
            cnt_q  <= 5'h0;
            rx_q   <= 16'h0000;
            tx_q   <= RESP_RESET;
            oe_q   <= 1'b0;
            req_q  <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            rx_q   <= rx_d;
            tx_q   <= tx_d;
            oe_q   <= oe_d;
            req_q  <= req_d;
            done_q <= done_d;
        end
    end

    // Request decode; bits 11:4 are never looked at
    always_comb begin
        rd_now  = done_q & req_q[READ_FLAG_POS];
        err_now = sleep_q | fault_q;
        tag     = {req_q[TAG2_POS], req_q[TAG1_POS], req_q[TAG0_POS]};
        part    = 4'h1 << req_q[1:0];
        word    = req_q[0] ? yh_q : xh_q;
        // High part: top ten bits; low part: four bits zero-padded
        low10   = req_q[1] ? word[SAMPLE_W-1:SAMPLE_W-10]
                           : {6'h00, word[3:0]};
    end

    // Readout: answer, sample holding and freeze bookkeeping
    always_comb begin
        logic [3:0] rdm;
        logic [1:0] pair;
        rdm    = rd_q | part;
        pair   = req_q[0] ? {rdm[3], rdm[1]} : {rdm[2], rdm[0]};
        resp_d = resp_q;
        frz_d  = frz_q;
        rd_d   = rd_q;
        xh_d   = xh_q;
        yh_d   = yh_q;
        // No capture in the read cycle, or a pair could straddle two samples
        if (SAMPLE_VALID && !rd_now) begin
            if (!frz_q[0]) begin
                xh_d = X_SAMPLE;
            end
            if (!frz_q[1]) begin
                yh_d = YZ_SAMPLE;
            end
        end
        if (pol_q == POL_FREE) begin
            frz_d = 2'h0;
            rd_d  = 4'h0;
        end
        if (rd_now) begin
            if (err_now) begin
                // Error report: unused and reserved bits stay zero
                resp_d = build_resp(tag, KIND_EXC,
                                    {EXC_KIND_SENS, 4'h0,
                                     sleep_q, fault_q, 2'h0});
            end else begin
                resp_d = build_resp(tag, (self_q | comp_q) ? KIND_SELF : KIND_NORMAL,
                                    low10);
                unique case (pol_q)
                    POL_ALL: begin
                        if (&rdm) begin
                            rd_d  = 4'h0;
                            frz_d = 2'h0;
                        end else begin
                            rd_d  = rdm;
                            frz_d = 2'h3;
                        end
                    end
                    POL_CHAN: begin
                        if (&pair) begin
                            rd_d             = req_q[0] ? (rdm & 4'h5) : (rdm & 4'ha);
                            frz_d[req_q[0]]  = 1'b0;
                        end else begin
                            rd_d             = rdm;
                            frz_d[req_q[0]]  = 1'b1;
                        end
                    end
                    POL_MSB: begin
                        // Low-part reads neither freeze nor release here
                        if (req_q[1]) begin
                            if (rdm[3] && rdm[2]) begin
                                rd_d  = 4'h0;
                                frz_d = 2'h0;
                            end else begin
                                rd_d  = rdm;
                                frz_d = 2'h3;
                            end
                        end
                    end
                    POL_FREE: begin
                        frz_d = 2'h0;
                        rd_d  = 4'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            resp_q <= RESP_RESET;
            xh_q   <= '0;
            yh_q   <= '0;
            frz_q  <= 2'h0;
            rd_q   <= 4'h0;
        end else begin
            resp_q <= resp_d;
            xh_q   <= xh_d;
            yh_q   <= yh_d;
            frz_q  <= frz_d;
            rd_q   <= rd_d;
        end
    end

    // All outputs straight from flops
    assign MISO          = tx_q[FRAME_BITS-1];
    assign MISO_OE       = oe_q;
    assign POWER_DOWN    = sleep_q;
    assign TEMP_COMP_OFF = comp_q;
    assign X_FROZEN      = frz_q[0];
    assign YZ_FROZEN     = frz_q[1];

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_resp_odd_parity: assert property (done_q |=> ^resp_q)
        else $error("response word lacks odd parity");
    a_tag_echo: assert property (rd_now |=> resp_q[15:13] == $past(tag))
        else $error("response tag differs from request tag");
    a_error_report: assert property (rd_now && err_now |=>
            resp_q[11:10] == KIND_EXC && resp_q[3] == $past(sleep_q)
            && resp_q[2] == $past(fault_q) && resp_q[7:4] == 4'h0
            && resp_q[9:8] == EXC_KIND_SENS && resp_q[1:0] == 2'h0)
        else $error("error read not reported as exception");
    a_selftest_kind: assert property (rd_now && !err_now && (self_q || comp_q) |=>
            resp_q[11:10] == KIND_SELF)
        else $error("self-test kind missing");
    a_normal_kind: assert property (rd_now && !err_now && !self_q && !comp_q |=>
            resp_q[11:10] == KIND_NORMAL && resp_q[9:0] == $past(low10))
        else $error("normal read returned wrong kind or data");
    a_low_part_pad: assert property (rd_now && !err_now && !req_q[1] |=>
            resp_q[9:4] == 6'h00)
        else $error("low part not zero padded");
    a_free_running: assert property (pol_q == POL_FREE |=> frz_q == 2'h0)
        else $error("outputs frozen in continuous mode");
    a_all_freeze: assert property (rd_now && !err_now && pol_q == POL_ALL
            && !(&(rd_q | part)) |=> frz_q == 2'h3 ##1 frz_q == 2'h3 || $past(rd_now))
        else $error("both channels not frozen after read");
    a_frozen_hold: assert property (frz_q[0] && $past(frz_q[0]) |-> $stable(xh_q))
        else $error("frozen x sample changed");
    a_first_bit: assert property (st_q == ST_IDLE && pins.ss_fall |=>
            tx_q == $past(resp_q) && oe_q)
        else $error("frame did not start with response word");

    c_normal_read:  cover property (rd_now && !err_now && !self_q && !comp_q);
    c_error_read:   cover property (rd_now && err_now);
    c_all_release:  cover property (frz_q == 2'h3 ##1 frz_q == 2'h0);
    c_chan_freeze:  cover property (pol_q == POL_CHAN && frz_q == 2'h2);
endmodule : asr_sample_readout

// ---- verif/asr_spi_master.sv ----
`timescale 1ns/1ps
// Behavioural master on the far side of the link, mode 0
module asr_spi_master (
    input  wire logic        clk,
    output logic             sck,
    output logic             ss_n,
    output logic             mosi,
    input  wire logic        miso,
    output logic [15:0]      resp_word,
    output logic             resp_strobe
);
    // Link clock parked low, slave released
    initial begin
        sck         = 1'b0;
        ss_n        = 1'b1;
        mosi        = 1'b0;
        resp_word   = 16'h0000;
        resp_strobe = 1'b0;
    end

    // One frame; half period of 4 system cycles gives a 400 ns period
    task automatic xfer(input logic [15:0] req, input int nbits);
        logic [15:0] got;
        got = 16'h0000;
        @(posedge clk);
        ss_n <= 1'b0;
        mosi <= req[15];
        // Extra wait so the first reply bit is out before the first rise
        repeat (6) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            // Late in the high phase, since the slave sees edges 4 cycles late
            got = {got[14:0], miso};
            sck  <= 1'b0;
            mosi <= (i < 15) ? req[14-i] : ~mosi;
            repeat (4) @(posedge clk);
        end
        ss_n        <= 1'b1;
        // Released data line shows the inverse of its last value
        mosi        <= ~mosi;
        resp_word   <= got;
        resp_strobe <= (nbits == 16);
        @(posedge clk);
        resp_strobe <= 1'b0;
        // Gap well above the 8-cycle minimum between frames
        repeat (11) @(posedge clk);
    endtask : xfer
endmodule : asr_spi_master

// ---- verif/asr_sample_readout_test.sv ----
`timescale 1ns/1ps
module asr_sample_readout_test;
    import asr_pkg::*;
    logic           clk, rst_n, sck, ss_n, mosi, miso, miso_oe;
    logic [13:0]    x_s, yz_s;          // Newest filter outputs
    logic           s_valid;            // New sample pulse
    asr_policy_type policy;             // Freeze policy
    logic           self_on, comp_off, sleep_req, loop_fault;
    logic           power_down, temp_comp_off, x_frozen, yz_frozen;
    logic [15:0]    resp_word;          // Word collected by the master
    logic           resp_strobe;        // Collected word complete
    logic [15:0]    exp_q[$];           // Expected replies, oldest first
    logic [15:0]    last_exp;           // Most recent expected reply
    logic [13:0]    hx, hy;             // Held samples the slave should report
    logic [31:0]    seed;               // Random state
    int             fail_count;
    int             checks_done;

    asr_sample_readout dut (
        .CLK(clk), .RST_N(rst_n), .SCK(sck), .SS_N(ss_n), .MOSI(mosi),
        .MISO(miso), .MISO_OE(miso_oe), .X_SAMPLE(x_s), .YZ_SAMPLE(yz_s),
        .SAMPLE_VALID(s_valid), .FREEZE_POLICY(policy), .SELF_CHECK_ON(self_on),
        .COMP_OFF(comp_off), .SLEEP_REQUEST(sleep_req), .LOOP_FAULT(loop_fault),
        .POWER_DOWN(power_down), .TEMP_COMP_OFF(temp_comp_off),
        .X_FROZEN(x_frozen), .YZ_FROZEN(yz_frozen)
    );
    asr_spi_master master (
        .clk(clk), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
        .resp_word(resp_word), .resp_strobe(resp_strobe)
    );

    // System clock, 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    task automatic chk_flag(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask : chk_flag

    task automatic flags(input logic ex, input logic ey);
        chk_flag("x_frozen", ex, x_frozen);
        chk_flag("yz_frozen", ey, yz_frozen);
    endtask : flags

    // Policy and control flags, then let the input registers settle
    task automatic setc(input asr_policy_type p, input logic [3:0] c);
        @(posedge clk);
        policy <= p;
        {self_on, comp_off, sleep_req, loop_fault} <= c;
        repeat (3) @(posedge clk);
    endtask : setc

    // New filter output; ux/uy say whether the held copy should follow
    task automatic newsamp(input logic ux, input logic uy, input logic neg);
        logic [13:0] xv;
        seed = lfsr_next(seed);
        xv   = neg ? 14'h3fff : seed[13:0];
        @(posedge clk);
        x_s     <= xv;
        yz_s    <= seed[29:16];
        s_valid <= 1'b1;
        if (ux) hx = xv;
        if (uy) hy = seed[29:16];
        @(posedge clk);
        s_valid <= 1'b0;
    endtask : newsamp

    // Sample read with random tag and junk; note the reply due next frame
    task automatic rd(input logic [1:0] sel);
        logic [2:0]  tag;
        logic [1:0]  kind;
        logic [9:0]  low;
        logic [13:0] s;
        seed = lfsr_next(seed);
        tag  = seed[2:0];
        s    = sel[0] ? hy : hx;
        low  = sel[1] ? s[13:4] : {6'h00, s[3:0]};
        kind = KIND_NORMAL;
        if (self_on || comp_off) kind = KIND_SELF;
        if (sleep_req || loop_fault) begin
            kind = KIND_EXC;
            low  = {EXC_KIND_SENS, 4'h0, sleep_req, loop_fault, 2'h0};
        end
        last_exp     = {tag, 1'b0, kind, low};
        last_exp[12] = ~^last_exp;
        exp_q.push_back(last_exp);
        master.xfer({tag[1:0], 1'b1, tag[2], seed[27:20], seed[9:8], sel}, 16);
    endtask : rd

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // Each complete frame carries the reply to the frame before it
    always @(posedge clk) begin
        if (resp_strobe === 1'b1) begin
            chk_flag("miso_oe", 1'b1, miso_oe);
            if (exp_q.size() == 0) begin
                chk_word("reply count", 16'h0000, 16'hffff);
            end else begin
                chk_word("reply", exp_q.pop_front(), resp_word);
            end
        end
    end

    // About 34 frames of 150 cycles; a hang is cut at nearly eight times that
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end

    initial begin
        {rst_n, x_s, yz_s, s_valid, self_on, comp_off, sleep_req, loop_fault} = '0;
        policy = POL_ALL;
        {hx, hy, fail_count, checks_done} = '0;
        seed = 32'h3b217fe4;
        last_exp = RESP_RESET;
        exp_q.push_back(RESP_RESET);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        flags(1'b0, 1'b0);
        chk_flag("power_down", 1'b0, power_down);
        chk_flag("temp_comp_off", 1'b0, temp_comp_off);
        chk_flag("miso_oe", 1'b0, miso_oe);
        // Free running: every part of both channels, one extreme value
        setc(POL_FREE, 4'h0);
        for (int n = 0; n < 3; n++) begin
            newsamp(1'b1, 1'b1, n == 0);
            for (int k = 0; k < 4; k++) rd(k[1:0]);
            flags(1'b0, 1'b0);
        end
        // Each status condition alone
        for (int c = 0; c < 4; c++) begin
            setc(POL_FREE, 4'h8 >> c);
            rd(c[1:0]);
            chk_flag("power_down", sleep_req, power_down);
            chk_flag("temp_comp_off", comp_off, temp_comp_off);
        end
        setc(POL_FREE, 4'h0);
        // Control request and short frame leave the reply untouched
        exp_q.push_back(last_exp);
        master.xfer(16'h4000, 16);
        master.xfer(16'h2003, 15);
        rd(2'h0);
        // Policy 00: both frozen until all four parts read
        setc(POL_ALL, 4'h0);
        newsamp(1'b1, 1'b1, 1'b0);
        rd(2'h2);
        flags(1'b1, 1'b1);
        newsamp(1'b0, 1'b0, 1'b0);
        rd(2'h3);
        rd(2'h0);
        flags(1'b1, 1'b1);
        rd(2'h1);
        flags(1'b0, 1'b0);
        newsamp(1'b1, 1'b1, 1'b0);
        rd(2'h0);
        // Policy 01: only the read channel waits for its pair
        setc(POL_FREE, 4'h0);
        setc(POL_CHAN, 4'h0);
        newsamp(1'b1, 1'b1, 1'b0);
        rd(2'h0);
        flags(1'b1, 1'b0);
        newsamp(1'b0, 1'b1, 1'b0);
        rd(2'h1);
        rd(2'h2);
        flags(1'b0, 1'b1);
        newsamp(1'b1, 1'b0, 1'b0);
        rd(2'h3);
        flags(1'b0, 1'b0);
        // Policy 10: a high part freezes both until the other high part
        setc(POL_FREE, 4'h0);
        setc(POL_MSB, 4'h0);
        newsamp(1'b1, 1'b1, 1'b0);
        rd(2'h0);
        flags(1'b0, 1'b0);
        newsamp(1'b1, 1'b1, 1'b0);
        rd(2'h2);
        rd(2'h1);
        flags(1'b1, 1'b1);
        newsamp(1'b0, 1'b0, 1'b0);
        rd(2'h3);
        flags(1'b0, 1'b0);
        newsamp(1'b1, 1'b1, 1'b0);
        rd(2'h0);
        // Flush frame brings out the last reply
        master.xfer(16'h4000, 16);
        stop_test();
    end
endmodule : asr_sample_readout_test
